// file: pgc_regs.svh
/*
 * Register map, field positions, reset values, function codes and timing
 * for the pin control block.
 * Assumes a word-addressed Wishbone view: byte address = 4 * index.
 */
`ifndef PGC_REGS_SVH
`define PGC_REGS_SVH

// register indices (byte address is four times the index)
`define PGC_CTRL_IDX        30'h0000_4041
`define PGC_STAT_IDX        30'h0000_4100
`define PGC_MASK_IDX        30'h0000_4101
`define PGC_DATA_IDX        30'h0000_4102

// control register fields
`define PGC_DIR_BIT         15
`define PGC_PULL_HI         14
`define PGC_PULL_LO         13
`define PGC_IRQ_MODE_BIT    12
`define PGC_SUPPLY_BIT      11
`define PGC_POL_BIT         10
`define PGC_OD_BIT          9
`define PGC_ENA_BIT         7
`define PGC_FN_HI           3
`define PGC_FN_LO           0
`define PGC_CTRL_RESET      16'hA400
`define PGC_CTRL_WMASK      16'hFE8F

// data and status register fields
`define PGC_DATA_OUT_BIT    0
`define PGC_DATA_IN_BIT     1
`define PGC_STAT_EDGE_BIT   0

// pull codes
`define PGC_PULL_NONE       2'h0
`define PGC_PULL_DOWN       2'h1
`define PGC_PULL_UP         2'h2

// function codes, shared by input and output lists
`define PGC_FN_0            4'h0
`define PGC_FN_1            4'h1
`define PGC_FN_2            4'h2
`define PGC_FN_3            4'h3
`define PGC_FN_4            4'h4
`define PGC_FN_5            4'h5
`define PGC_FN_6            4'h6
`define PGC_FN_7            4'h7
`define PGC_FN_8            4'h8
`define PGC_FN_9            4'h9
`define PGC_FN_10           4'hA
`define PGC_FN_11           4'hB
`define PGC_FN_12           4'hC
`define PGC_FN_13           4'hD
`define PGC_FN_14           4'hE
`define PGC_FN_15           4'hF

// input function output vector positions
`define PGC_FI_ONOFF        0
`define PGC_FI_SLPWAKE      1
`define PGC_FI_SLEEP        2
`define PGC_FI_PWRON        3
`define PGC_FI_WDOG         4
`define PGC_FI_VS1          5
`define PGC_FI_VS2          6
`define PGC_FI_HWEN1        7
`define PGC_FI_HWEN2        8
`define PGC_FI_HWCTL1       9
`define PGC_FI_HWCTL2       10

// timing
`define PGC_CLK_MHZ         20
`define PGC_LONG_DB_US      1000

`endif

// file: pgc_pkg.sv
/*
 * Types for the pin control block.
 * Assumes pgc_regs.svh for all numeric constants.
 */
package pgc_pkg;

	// whole state of the pin control top
	typedef struct packed {
		logic [15:0] ctrl;
		logic        gpo;
		logic        mask;
		logic        stat;
		logic        ack;
		logic [31:0] rdat;
		logic        pin_s;
		logic        lvl_prev;
		logic        irq;
		logic        pad_out;
		logic        pad_oe;
		logic        pull_up;
		logic        pull_dn;
		logic        supply;
		logic        gpio_in;
		logic [10:0] fin;
	} pgc_state_t;

	// state of the settle filter
	typedef struct packed {
		logic [19:0] cnt;
		logic        q;
	} pgc_db_state_t;

endpackage

// file: pgc_debounce.sv
/*
 * Settle filter: output follows input after it has been stable for
 * STABLE_CYCLES clocks.
 * Assumes d is already synchronous to clock.
 */
`timescale 1ns/1ps
`include "pgc_regs.svh"

module pgc_debounce #(
	parameter int unsigned STABLE_CYCLES = `PGC_LONG_DB_US * `PGC_CLK_MHZ
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic resetn,
	// level in and filtered level out
	input  wire logic d,
	output logic      q
);

	pgc_pkg::pgc_db_state_t s_q;
	pgc_pkg::pgc_db_state_t s_d;

	// count while input differs from output, restart on any bounce
	always_comb begin
		s_d = s_q;
		if (d == s_q.q) begin
			s_d.cnt = '0;
		end else if (s_q.cnt >= 20'(STABLE_CYCLES - 1)) begin
			s_d.cnt = '0;
			s_d.q   = d;
		end else begin
			s_d.cnt = s_q.cnt + 20'h0001;
		end
	end

	// state register
	always_ff @(posedge clock) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q.q;

endmodule // pgc_debounce

// file: pgc_pin_control.sv
/*
 * Control logic of one general-purpose pin: control register on classic
 * Wishbone, input function routing, output function muxing, pad drive,
 * edge interrupt with status and mask.
 * Assumes pad_in and all function sources are synchronous to clock, and
 * that the pad cell builds the wire from pad_out/pad_oe and the pulls.
 */
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "pgc_regs.svh"

// Functional notes
// - direction bit 15: 0 output, 1 input
// - pull field: none, down, up; resets down
// - edge interrupt: polarity edge, or both edges
// - bit 11 picks digital or alternate supply
// - bit 10: 0 inverted, 1 non-inverted
// - bit 9: 0 push-pull, 1 open-drain
// - bit 7: 0 tri-stated, 1 normal
// - input codes 0,1 gpio; 0 long debounce
// - input 2 power on/off, 3 sleep/wake
// - input 4 debounced sleep/wake, 5 sleep, 6 power-on
// - input 7 is watchdog reset input
// - input 8,9 voltage scale; 10,11 hw enable
// - input 12-15 hw control, 14,15 debounced
// - output 0 gpio level, 1 32 kHz clock
// - output 2 on, 3 sleep, 4 change
// - output 8,9 scale done; 12,13 supply good
// - output 10,11 external power enables
// - output 14 2 MHz clock, 15 aux reset
module pgc_pin_control #(
	parameter int unsigned LONG_DB_CYCLES = `PGC_LONG_DB_US * `PGC_CLK_MHZ
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        resetn,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// interrupt
	output logic             irq_o,
	// pad
	input  wire logic        pad_in,
	output logic             pad_out,
	output logic             pad_oe,
	output logic             pull_up_en,
	output logic             pull_down_en,
	output logic             supply_domain_select,
	// input functions towards the device
	output logic             power_onoff_req,
	output logic             sleep_wake_req,
	output logic             sleep_req,
	output logic             power_on_req,
	output logic             wdog_reset_in,
	output logic             voltage_scale_in_one,
	output logic             voltage_scale_in_two,
	output logic             hw_enable_one,
	output logic             hw_enable_two,
	output logic             hw_control_one,
	output logic             hw_control_two,
	// output function sources from the device
	input  wire logic        osc_32k_clk,
	input  wire logic        on_state,
	input  wire logic        sleep_state,
	input  wire logic        power_state_change,
	input  wire logic        scale_done_one,
	input  wire logic        scale_done_two,
	input  wire logic        ext_power_enable_one,
	input  wire logic        ext_power_enable_two,
	input  wire logic        system_supply_good,
	input  wire logic        converter_power_good,
	input  wire logic        ext_power_clk_2m,
	input  wire logic        aux_reset
);

	// whole block state, registered once per clock
	pgc_pkg::pgc_state_t s_q;
	pgc_pkg::pgc_state_t s_d;

	// settled pad level from the long filter
	logic       lvl_filt;

	// control field views, plain slices of the register
	logic       pin_direction;
	logic [1:0] pull_select;
	logic       irq_edge_mode;
	logic       pin_polarity;
	logic       open_drain_select;
	logic       pin_enable;
	logic [3:0] pin_function_select;

	// control field views
	assign pin_direction       = s_q.ctrl[`PGC_DIR_BIT];
	assign pull_select         = s_q.ctrl[`PGC_PULL_HI:`PGC_PULL_LO];
	assign irq_edge_mode       = s_q.ctrl[`PGC_IRQ_MODE_BIT];
	assign pin_polarity        = s_q.ctrl[`PGC_POL_BIT];
	assign open_drain_select   = s_q.ctrl[`PGC_OD_BIT];
	assign pin_enable          = s_q.ctrl[`PGC_ENA_BIT];
	assign pin_function_select = s_q.ctrl[`PGC_FN_HI:`PGC_FN_LO];

	// long settle filter on the sampled pad level
	pgc_debounce #(
		.STABLE_CYCLES (LONG_DB_CYCLES)
	) u_long_db (
		.clock  (clock),
		.resetn (resetn),
		.d      (s_q.pin_s),
		.q      (lvl_filt)
	);

	// next state of the whole block
	always_comb begin
		// bus temporaries
		logic        hit;
		logic        rd;
		logic        wr;
		logic        a_ctrl;
		logic        a_stat;
		logic        a_mask;
		logic        a_data;
		logic [15:0] bmask;

		// pin path temporaries
		logic        long_db;
		logic        lvl;
		logic        in_act;
		logic        out_act;
		logic        edge_ev;
		logic        src;
		logic        drive;

		s_d     = s_q;
		hit     = wb_cyc_i & wb_stb_i & ~s_q.ack;
		rd      = hit & ~wb_we_i;
		wr      = hit & wb_we_i;
		a_ctrl  = 1'b0;
		a_stat  = 1'b0;
		a_mask  = 1'b0;
		a_data  = 1'b0;
		bmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		long_db = 1'b0;
		lvl     = 1'b0;
		in_act  = 1'b0;
		out_act = 1'b0;
		edge_ev = 1'b0;
		src     = 1'b0;
		drive   = 1'b0;

		// address decode, word aligned
		if (wb_adr_i[31:2] == `PGC_CTRL_IDX) begin
			a_ctrl = 1'b1;
		end else if (wb_adr_i[31:2] == `PGC_STAT_IDX) begin
			a_stat = 1'b1;
		end else if (wb_adr_i[31:2] == `PGC_MASK_IDX) begin
			a_mask = 1'b1;
		end else if (wb_adr_i[31:2] == `PGC_DATA_IDX) begin
			a_data = 1'b1;
		end

		// ack one cycle after the strobe, dropped the cycle after
		s_d.ack = hit;

		// writes; reserved control bits never stored so they read zero
		if (wr && a_ctrl) begin
			s_d.ctrl = (s_q.ctrl & ~(bmask & `PGC_CTRL_WMASK))
			         | (wb_dat_i[15:0] & bmask & `PGC_CTRL_WMASK);
		end

		// mask and output level live in byte lane zero
		if (wr && a_mask && wb_sel_i[0]) begin
			s_d.mask = wb_dat_i[`PGC_STAT_EDGE_BIT];
		end

		// only the output level is writable in the data word
		if (wr && a_data && wb_sel_i[0]) begin
			s_d.gpo = wb_dat_i[`PGC_DATA_OUT_BIT];
		end

		// read data; unmapped addresses answer zero
		s_d.rdat = '0;
		if (rd) begin
			if (a_ctrl) begin
				s_d.rdat[15:0] = s_q.ctrl;
			end else if (a_stat) begin
				s_d.rdat[`PGC_STAT_EDGE_BIT] = s_q.stat;
			end else if (a_mask) begin
				s_d.rdat[`PGC_STAT_EDGE_BIT] = s_q.mask;
			end else if (a_data) begin
				s_d.rdat[`PGC_DATA_OUT_BIT] = s_q.gpo;
				s_d.rdat[`PGC_DATA_IN_BIT]  = s_q.gpio_in;
			end
		end

		// pad sampled once; inputs are already synchronous
		s_d.pin_s = pad_in;

		// direction and enable pick which list applies
		in_act  = pin_direction & pin_enable;
		out_act = ~pin_direction & pin_enable;

		// long settle only for codes 0, 4, 14 and 15
		long_db = (pin_function_select == `PGC_FN_0)
		        | (pin_function_select == `PGC_FN_4)
		        | (pin_function_select == `PGC_FN_14)
		        | (pin_function_select == `PGC_FN_15);

		// logical level: inverted polarity flips the pad level
		lvl = (long_db ? lvl_filt : s_q.pin_s) ^ ~pin_polarity;

		// edge on logical level: rising only, or both in edge mode
		edge_ev = in_act & (lvl ^ s_q.lvl_prev) & (irq_edge_mode | lvl);

		// tracked while inactive too, so enabling alone makes no edge
		s_d.lvl_prev = lvl;

		// sticky status; a new edge wins over the read clear
		s_d.stat = edge_ev | (s_q.stat & ~(rd & a_stat));

		// level interrupt from the next status, so it rises with the bit
		s_d.irq  = s_d.stat & s_d.mask;

		// input function routing, all inactive unless input and enabled
		s_d.fin     = '0;
		s_d.gpio_in = 1'b0;
		if (in_act) begin
			case (pin_function_select)
				`PGC_FN_0, `PGC_FN_1: begin
					s_d.gpio_in = lvl;
				end
				`PGC_FN_2: begin
					s_d.fin[`PGC_FI_ONOFF] = lvl;
				end
				`PGC_FN_3: begin
					s_d.fin[`PGC_FI_SLPWAKE] = lvl;
				end
				`PGC_FN_4: begin
					s_d.fin[`PGC_FI_SLPWAKE] = lvl;
				end
				`PGC_FN_5: begin
					s_d.fin[`PGC_FI_SLEEP] = lvl;
				end
				`PGC_FN_6: begin
					s_d.fin[`PGC_FI_PWRON] = lvl;
				end
				`PGC_FN_7: begin
					s_d.fin[`PGC_FI_WDOG] = lvl;
				end
				`PGC_FN_8: begin
					s_d.fin[`PGC_FI_VS1] = lvl;
				end
				`PGC_FN_9: begin
					s_d.fin[`PGC_FI_VS2] = lvl;
				end
				`PGC_FN_10: begin
					s_d.fin[`PGC_FI_HWEN1] = lvl;
				end
				`PGC_FN_11: begin
					s_d.fin[`PGC_FI_HWEN2] = lvl;
				end
				`PGC_FN_12, `PGC_FN_14: begin
					s_d.fin[`PGC_FI_HWCTL1] = lvl;
				end
				default: begin
					s_d.fin[`PGC_FI_HWCTL2] = lvl;
				end
			endcase
		end

		// output function source; reserved codes drive inactive
		case (pin_function_select)
			`PGC_FN_0:  src = s_q.gpo;
			`PGC_FN_1:  src = osc_32k_clk;
			`PGC_FN_2:  src = on_state;
			`PGC_FN_3:  src = sleep_state;
			`PGC_FN_4:  src = power_state_change;
			`PGC_FN_8:  src = scale_done_one;
			`PGC_FN_9:  src = scale_done_two;
			`PGC_FN_10: src = ext_power_enable_one;
			`PGC_FN_11: src = ext_power_enable_two;
			`PGC_FN_12: src = system_supply_good;
			`PGC_FN_13: src = converter_power_good;
			`PGC_FN_14: src = ext_power_clk_2m;
			`PGC_FN_15: src = aux_reset;
			default:    src = 1'b0;
		endcase
		drive = src ^ ~pin_polarity;

		// pad drive; open drain only ever pulls low
		if (open_drain_select) begin
			s_d.pad_out = 1'b0;
			s_d.pad_oe  = out_act & ~drive;
		end else begin
			s_d.pad_out = drive;
			s_d.pad_oe  = out_act;
		end

		// pulls and supply follow the register regardless of enable
		s_d.pull_up = (pull_select == `PGC_PULL_UP);
		s_d.pull_dn = (pull_select == `PGC_PULL_DOWN);

		// supply choice only steers the pad cell
		s_d.supply  = s_q.ctrl[`PGC_SUPPLY_BIT];
	end

	// state register; reset values match the documented control defaults
	always_ff @(posedge clock) begin
		if (!resetn) begin
			s_q <= '{ctrl: `PGC_CTRL_RESET, pull_dn: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign wb_dat_o             = s_q.rdat;
	assign wb_ack_o             = s_q.ack;

	// interrupt level
	assign irq_o                = s_q.irq;

	// pad drive, pulls and supply
	assign pad_out              = s_q.pad_out;
	assign pad_oe               = s_q.pad_oe;
	assign pull_up_en           = s_q.pull_up;
	assign pull_down_en         = s_q.pull_dn;
	assign supply_domain_select = s_q.supply;

	// input functions, all low unless routed
	assign power_onoff_req      = s_q.fin[`PGC_FI_ONOFF];
	assign sleep_wake_req       = s_q.fin[`PGC_FI_SLPWAKE];
	assign sleep_req            = s_q.fin[`PGC_FI_SLEEP];
	assign power_on_req         = s_q.fin[`PGC_FI_PWRON];
	assign wdog_reset_in        = s_q.fin[`PGC_FI_WDOG];
	assign voltage_scale_in_one = s_q.fin[`PGC_FI_VS1];
	assign voltage_scale_in_two = s_q.fin[`PGC_FI_VS2];
	assign hw_enable_one        = s_q.fin[`PGC_FI_HWEN1];
	assign hw_enable_two        = s_q.fin[`PGC_FI_HWEN2];
	assign hw_control_one       = s_q.fin[`PGC_FI_HWCTL1];
	assign hw_control_two       = s_q.fin[`PGC_FI_HWCTL2];

endmodule // pgc_pin_control

// file: pgc_pin_control_props.sv
/*
 * Checker for the pin control block: bus handshake, pulls, supply, pad drive.
 * Assumes it is bound into pgc_pin_control and sees only its ports.
 */
`timescale 1ns/1ps
`include "pgc_regs.svh"

module pgc_pin_control_props (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        resetn,
	// bus
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	// pad
	input  wire logic        pad_out,
	input  wire logic        pad_oe,
	input  wire logic        pull_up_en,
	input  wire logic        pull_down_en,
	input  wire logic        supply_domain_select,
	// output function sources
	input  wire logic        osc_32k_clk,
	input  wire logic        on_state,
	input  wire logic        sleep_state,
	input  wire logic        power_state_change,
	input  wire logic        scale_done_one,
	input  wire logic        scale_done_two,
	input  wire logic        ext_power_enable_one,
	input  wire logic        ext_power_enable_two,
	input  wire logic        system_supply_good,
	input  wire logic        converter_power_good,
	input  wire logic        ext_power_clk_2m,
	input  wire logic        aux_reset
);
	logic [15:0] c_q;
	logic [15:0] w;
	logic [15:0] s;
	logic        ph;

	// shadow control word, taken at the edge the slave accepts a write
	assign w = {wb_sel_i[1] ? wb_dat_i[15:8] : c_q[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : c_q[7:0]};
	always_ff @(posedge clock) begin
		if (!resetn)
			c_q <= `PGC_CTRL_RESET;
		else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i[31:2] == `PGC_CTRL_IDX)
			c_q <= w & `PGC_CTRL_WMASK;
	end

	// source per output code; code 0 comes from a register we cannot see
	assign s = {aux_reset, ext_power_clk_2m, converter_power_good, system_supply_good, ext_power_enable_two,
		ext_power_enable_one, scale_done_two, scale_done_one, 3'h0, power_state_change, sleep_state,
		on_state, osc_32k_clk, 1'b0};
	assign ph = s[c_q[3:0]] ~^ c_q[10];

	a_ack_prompt: assert property (@(posedge clock) disable iff (!resetn)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
	a_ack_pulse: assert property (@(posedge clock) disable iff (!resetn)
		wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_dat_idle: assert property (@(posedge clock) disable iff (!resetn)
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data outside ack");
	a_pull_decode: assert property (@(posedge clock) disable iff (!resetn)
		pull_down_en == ($past(c_q[14:13]) == 2'h1) && pull_up_en == ($past(c_q[14:13]) == 2'h2))
		else $error("pull decode wrong");
	a_supply_sel: assert property (@(posedge clock) disable iff (!resetn)
		supply_domain_select == $past(c_q[11])) else $error("supply select wrong");
	a_tri_state: assert property (@(posedge clock) disable iff (!resetn)
		!c_q[7] && !$past(c_q[7]) |-> !pad_oe) else $error("disabled pin driven");
	a_input_float: assert property (@(posedge clock) disable iff (!resetn)
		c_q[15] && $past(c_q[15]) |-> !pad_oe) else $error("input pin driven");
	a_out_route: assert property (@(posedge clock) disable iff (!resetn)
		c_q[7] && !c_q[15] && !c_q[9] && c_q[3:0] != 4'h0 && $stable(c_q) |-> pad_oe && pad_out == $past(ph))
		else $error("output route wrong");
	a_open_drain: assert property (@(posedge clock) disable iff (!resetn)
		c_q[7] && !c_q[15] && c_q[9] && c_q[3:0] != 4'h0 && $stable(c_q) |->
		pad_oe == !$past(ph) && !(pad_oe && pad_out)) else $error("open drain wrong");
endmodule // pgc_pin_control_props

bind pgc_pin_control pgc_pin_control_props pgc_pin_control_props_inst (.*);

// file: pgc_pin_model.sv
/*
 * Board-side model of the pin: drives it on request, else pulls settle it.
 * Assumes pad_oe high means the device drives the wire.
 */
`timescale 1ns/1ps

module pgc_pin_model (
	// clock
	input  wire logic clock,
	// device side of the pad
	input  wire logic pad_out,
	input  wire logic pad_oe,
	input  wire logic pull_up_en,
	input  wire logic pull_down_en,
	// board drive
	input  wire logic drv_en,
	input  wire logic drv_lvl,
	// resolved wire
	output logic      pad_in
);
	logic fl_q = 1'b0;

	// a floating wire never keeps its last level
	always_ff @(posedge clock)
		fl_q <= !pad_in;

	// device drive wins, then board drive; an undriven wire goes to the pull, else wanders
	always_comb begin
		if (pad_oe)
			pad_in = pad_out;
		else if (drv_en)
			pad_in = drv_lvl;
		else if (pull_up_en)
			pad_in = 1'b1;
		else if (pull_down_en)
			pad_in = 1'b0;
		else
			pad_in = fl_q;
	end
endmodule // pgc_pin_model

// file: tb.sv
/*
 * Self-checking bench: registers, output and input routing, edge interrupt.
 * Assumes pgc_pin_model on the pad and the checker bound in.
 */
`timescale 1ns/1ps
`include "pgc_regs.svh"

module tb;
	logic        clock, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, drv_en, drv_lvl;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, r;
	logic [3:0]  wb_sel_i;
	logic        pad_in, pad_out, pad_oe, pull_up_en, pull_down_en, supply_domain_select, p;
	logic        power_onoff_req, sleep_wake_req, sleep_req, power_on_req, wdog_reset_in;
	logic        voltage_scale_in_one, voltage_scale_in_two, hw_enable_one, hw_enable_two;
	logic        hw_control_one, hw_control_two, osc_32k_clk, on_state, sleep_state;
	logic        power_state_change, scale_done_one, scale_done_two, ext_power_enable_one;
	logic        ext_power_enable_two, system_supply_good, converter_power_good, ext_power_clk_2m, aux_reset;
	logic [15:0] srcv, v, sx;
	logic [10:0] fns;
	int          fail_count, n_tests, seed, i;
	localparam logic [31:0] A_CTRL = {`PGC_CTRL_IDX, 2'h0};
	localparam logic [31:0] A_STAT = {`PGC_STAT_IDX, 2'h0};
	localparam logic [31:0] A_MASK = {`PGC_MASK_IDX, 2'h0};
	localparam logic [31:0] A_DATA = {`PGC_DATA_IDX, 2'h0};

	// sources and input functions gathered in code order
	assign {aux_reset, ext_power_clk_2m, converter_power_good, system_supply_good} = srcv[15:12];
	assign {ext_power_enable_two, ext_power_enable_one, scale_done_two, scale_done_one} = srcv[11:8];
	assign {power_state_change, sleep_state, on_state, osc_32k_clk} = srcv[4:1];
	assign fns = {hw_control_two, hw_control_one, hw_enable_two, hw_enable_one, voltage_scale_in_two,
		voltage_scale_in_one, wdog_reset_in, power_on_req, sleep_req, sleep_wake_req, power_onoff_req};

	pgc_pin_control #(.LONG_DB_CYCLES(4)) pgc_pin_control_inst (.*);
	pgc_pin_model pgc_pin_model_inst (.*);

	// clock
	initial begin
		clock = 1'b0;
		forever #25 clock = !clock;
	end

	task automatic wrap_up();
		if (fail_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one classic cycle, held until ack is sampled, bounded wait
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (k >= 20) begin
			fail_count++;
			$display("BAD %0t no ack", $time);
			wrap_up();
		end
		@(posedge clock);
	endtask

	// expected input function vector for a code
	function automatic logic [10:0] fin_exp(input logic [3:0] c);
		logic [10:0] e;
		e = 11'h000;
		case (c)
			4'h2: e[`PGC_FI_ONOFF] = 1'b1;
			4'h3, 4'h4: e[`PGC_FI_SLPWAKE] = 1'b1;
			4'h5: e[`PGC_FI_SLEEP] = 1'b1;
			4'h6: e[`PGC_FI_PWRON] = 1'b1;
			4'h7: e[`PGC_FI_WDOG] = 1'b1;
			4'h8: e[`PGC_FI_VS1] = 1'b1;
			4'h9: e[`PGC_FI_VS2] = 1'b1;
			4'hA: e[`PGC_FI_HWEN1] = 1'b1;
			4'hB: e[`PGC_FI_HWEN2] = 1'b1;
			4'hC, 4'hE: e[`PGC_FI_HWCTL1] = 1'b1;
			4'hD, 4'hF: e[`PGC_FI_HWCTL2] = 1'b1;
			default: e = 11'h000;
		endcase
		return e;
	endfunction

	// enabled control word, pull-down
	function automatic logic [15:0] cw(input logic dir, input logic md, input logic pol, input logic od,
		input logic [3:0] c);
		return {dir, 2'h1, md, 1'b0, pol, od, 1'b0, 1'b1, 3'h0, c};
	endfunction

	initial begin
		seed = 32'h0000_ab3d;
		fail_count = 0;
		n_tests = 0;
		{resetn, wb_cyc_i, wb_stb_i, wb_we_i, drv_en, drv_lvl} <= 6'h00;
		{wb_adr_i, wb_dat_i, srcv} <= 80'h0;
		wb_sel_i <= 4'hf;
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		wb(1'b0, A_CTRL, 32'h0);
		chk(r, 32'h0000_a400);
		chk(32'(pull_down_en), 32'h1);
		wb(1'b0, 32'h0000_0200, 32'h0);
		chk(r, 32'h0);
		// random control words read back through the writable mask
		for (i = 0; i < 6; i++) begin
			v = 16'($random(seed));
			wb(1'b1, A_CTRL, {16'h0, v});
			wb(1'b0, A_CTRL, 32'h0);
			chk(r, {16'h0, v & 16'hfe8f});
			chk(32'(supply_domain_select), 32'(v[11]));
			chk(32'({pull_up_en, pull_down_en}), 32'({v[14:13] == 2'h2, v[14:13] == 2'h1}));
		end
		wb(1'b1, 32'h0000_0200, 32'hffff_ffff);
		wb(1'b0, A_CTRL, 32'h0);
		chk(r, {16'h0, v & 16'hfe8f});
		// low byte lane alone: direction and pulls keep their value
		wb_sel_i <= 4'h1;
		wb(1'b1, A_CTRL, 32'h0000_ffff);
		wb_sel_i <= 4'hf;
		wb(1'b0, A_CTRL, 32'h0);
		chk(r, {16'h0, v[15:8] & 8'hfe, 8'h8f});
		// every output code with random sources, polarity and drive type
		for (i = 0; i < 16; i++) begin
			v = 16'($random(seed));
			sx = {v[15:8], 3'h0, v[4:0]};
			srcv <= sx;
			wb(1'b1, A_DATA, {31'h0, v[0]});
			wb(1'b1, A_CTRL, {16'h0, cw(1'b0, 1'b0, v[6], v[5], i[3:0])});
			repeat (2) @(posedge clock);
			p = sx[i] ~^ v[6];
			chk(32'({pad_oe, pad_out & pad_oe}), 32'({v[5] ? !p : 1'b1, v[5] ? 1'b0 : p}));
			chk(32'(fns), 32'h0);
		end
		// every input code, board drives the active level then the idle one
		drv_en <= 1'b1;
		for (i = 0; i < 16; i++) begin
			v = 16'($random(seed));
			wb(1'b1, A_CTRL, {16'h0, cw(1'b1, 1'b0, v[0], 1'b0, i[3:0])});
			drv_lvl <= v[0];
			repeat (12) @(posedge clock);
			chk(32'(fns), 32'(fin_exp(i[3:0])));
			wb(1'b0, A_DATA, 32'h0);
			chk(32'(r[1]), 32'(i < 2));
			drv_lvl <= !v[0];
			repeat (12) @(posedge clock);
			chk(32'(fns), 32'h0);
		end
		// edge modes for both polarities: pad rises, then falls
		wb(1'b1, A_MASK, 32'h1);
		for (i = 0; i < 4; i++) begin
			drv_lvl <= 1'b0;
			wb(1'b1, A_CTRL, {16'h0, cw(1'b1, i[1], i[0], 1'b0, 4'h1)});
			repeat (4) @(posedge clock);
			wb(1'b0, A_STAT, 32'h0);
			drv_lvl <= 1'b1;
			repeat (5) @(posedge clock);
			chk(32'(irq_o), 32'(i[1] | i[0]));
			wb(1'b0, A_STAT, 32'h0);
			chk(r, 32'(i[1] | i[0]));
			chk(32'(irq_o), 32'h0);
			drv_lvl <= 1'b0;
			repeat (5) @(posedge clock);
			wb(1'b0, A_STAT, 32'h0);
			chk(r, 32'(i[1] | !i[0]));
		end
		// masked event is recorded but stays quiet
		wb(1'b1, A_MASK, 32'h0);
		drv_lvl <= 1'b1;
		repeat (5) @(posedge clock);
		chk(32'(irq_o), 32'h0);
		wb(1'b0, A_STAT, 32'h0);
		chk(r, 32'h1);
		// disabled input pin routes nothing and raises no event
		wb(1'b1, A_CTRL, 32'h0000_a402);
		drv_lvl <= 1'b0;
		repeat (6) @(posedge clock);
		chk(32'({fns, pad_oe}), 32'h0);
		wb(1'b0, A_STAT, 32'h0);
		chk(r, 32'h0);
		// disabled output with pull-up: no drive, pull still applied
		wb(1'b1, A_CTRL, 32'h0000_4401);
		repeat (3) @(posedge clock);
		chk(32'({pad_oe, pull_up_en, pull_down_en}), 32'h0000_0002);
		wrap_up();
	end
endmodule // tb
